// file: core/dpr_consts.svh
// timing counts, rates and reset values for the device phy power and recovery machine
// assumes a single phy clock of 100 MHz; included by bare name
`ifndef DPR_CONSTS_SVH
`define DPR_CONSTS_SVH

// clock period in ns
`define DPR_CLK_PERIOD_NS 10
// alignment send window before giving up, 54.6 us written in ns
`define DPR_ALIGN_TIME_NS 54600
// least time, so round up to whole cycles
`define DPR_ALIGN_CYCLES ((`DPR_ALIGN_TIME_NS + `DPR_CLK_PERIOD_NS - 1) / `DPR_CLK_PERIOD_NS)
// asynchronous recovery timeout in us, a plain default
`define DPR_RECOV_TIME_US 10000
`define DPR_RECOV_CYCLES ((`DPR_RECOV_TIME_US * 1000 + `DPR_CLK_PERIOD_NS - 1) / `DPR_CLK_PERIOD_NS)
// timer width, wide enough for the recovery count
`define DPR_TMR_W 24
// signaling generations: fastest used after reset, lowest is the floor
`define DPR_GEN_MAX 2'h2
`define DPR_GEN_MIN 2'h1
// number of pin inputs passed through the synchroniser
`define DPR_SYNC_W 5

`endif

// file: core/dpr_pkg.sv
// types for the device phy power and recovery machine
// assumes dpr_consts.svh is on the include path
`default_nettype none
`include "dpr_consts.svh"
package dpr_pkg;

  typedef enum logic [3:0] {
    reset_state,
    wake_signal_state,
    await_wake_release_state,
    send_align_state,
    ready_state,
    partial_power_state,
    slumber_power_state,
    reduce_speed_state,
    error_state
  } dpr_state_t;

  typedef struct packed {
    dpr_state_t st;
    logic [`DPR_SYNC_W-1:0] sy1;
    logic [`DPR_SYNC_W-1:0] sy2;
    logic [1:0] rate;
    logic resuming;
    logic phy_ready;
    logic quiescent;
    logic tx_align;
    logic tx_wake;
    logic rate_req;
  } dpr_core_t;

endpackage
`default_nettype wire

// file: core/dpr_timer.sv
// elapsed-cycle timer: counts while clear is low, flags done at limit cycles
// assumes a synchronous-release reset from the top and limit of at least one
`timescale 1ns/1ps
`default_nettype none
module dpr_timer #(
  parameter int W = 24
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic [W-1:0] limit,
  output logic done
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } dpr_tmr_t;

  dpr_tmr_t q;
  dpr_tmr_t next_q;

  // count stops once done so it never wraps back to a false expiry
  always_comb begin
    next_q = q;
    if (clear) begin
      next_q = '0;
    end else if (!q.done) begin
      next_q.cnt = q.cnt + 1'b1;
      next_q.done = (next_q.cnt == limit);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign done = q.done;

endmodule // dpr_timer
`default_nettype wire

// file: core/dpr_fsm.sv
// device phy power-state, speed-reduction and error-recovery state machine
// assumes link requests come from logic on mclk and analog status from outside the domain
//
// Operation
// - phy ready only in ready state with receiver locked and transmitter valid.
// - partial holds while requested; on drop go wake, or await release if host wakes.
// - slumber holds while requested; on drop go wake, or await release if host wakes.
// - reduce-speed moves to send-align once slower rate switch completes.
// - reduce-speed stays put while the rate switch is incomplete.
// - rate switch complete only when transmitter sends valid signal at new rate.
// - error state holds when not a failed wake and no recovery timeout.
// - error after failed power-state resume goes to wake to retry.
// - with async recovery, error goes to reset after the recovery timeout.
// - resume keeps negotiated rate; align failure goes straight to error.
// - no host align after 54.6 us above lowest rate goes to reduce-speed.
`timescale 1ns/1ps
`default_nettype none
`include "dpr_consts.svh"
module dpr_fsm #(
  parameter int ALIGN_CYCLES = `DPR_ALIGN_CYCLES,
  parameter int RECOV_CYCLES = `DPR_RECOV_CYCLES,
  parameter bit ASYNC_RECOVERY = 1'b1,
  parameter logic [1:0] GEN_MAX = `DPR_GEN_MAX,
  parameter logic [1:0] GEN_MIN = `DPR_GEN_MIN,
  parameter int TMR_W = `DPR_TMR_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic link_partial_req,
  input wire logic link_slumber_req,
  input wire logic rx_sync_lock,
  input wire logic tx_signal_valid,
  input wire logic host_align_det,
  input wire logic host_wake_det,
  input wire logic speed_switch_done,
  output logic phy_ready_ind,
  output logic iface_quiescent,
  output logic tx_align,
  output logic tx_wake,
  output logic rate_change_req,
  output logic [1:0] rate_gen
);

  logic [1:0] rst_ff;
  logic rst_q;
  dpr_pkg::dpr_core_t q;
  dpr_pkg::dpr_core_t next_q;
  logic align_done;
  logic recov_done;
  logic rx_s;
  logic txv_s;
  logic align_s;
  logic wake_s;
  logic spd_s;

  // reset released through two flops so every state flop leaves reset on one edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_q = rst_ff[1];

  // only the second synchroniser stage is ever looked at
  assign rx_s = q.sy2[4];
  assign txv_s = q.sy2[3];
  assign align_s = q.sy2[2];
  assign wake_s = q.sy2[1];
  assign spd_s = q.sy2[0];

  // window timers, each held clear outside the state it measures
  dpr_timer #(.W(TMR_W)) u_align_tmr (
    .mclk(mclk),
    .rst_n(rst_q),
    .clear(q.st != dpr_pkg::send_align_state),
    .limit(TMR_W'(ALIGN_CYCLES)),
    .done(align_done)
  );

  dpr_timer #(.W(TMR_W)) u_recov_tmr (
    .mclk(mclk),
    .rst_n(rst_q),
    .clear(q.st != dpr_pkg::error_state),
    .limit(TMR_W'(RECOV_CYCLES)),
    .done(recov_done)
  );

  // next state; outputs derive from the next state so they line up with it
  always_comb begin
    next_q = q;
    next_q.sy1 = {rx_sync_lock, tx_signal_valid, host_align_det, host_wake_det,
                  speed_switch_done};
    next_q.sy2 = q.sy1;
    unique case (q.st)
      dpr_pkg::reset_state: begin
        // recovery restarts at the fastest rate; earlier handshakes are out of scope
        next_q.rate = GEN_MAX;
        next_q.resuming = 1'b0;
        next_q.st = dpr_pkg::wake_signal_state;
      end
      dpr_pkg::wake_signal_state: begin
        if (wake_s) begin
          next_q.st = dpr_pkg::await_wake_release_state;
        end
      end
      dpr_pkg::await_wake_release_state: begin
        if (!wake_s) begin
          next_q.st = dpr_pkg::send_align_state;
        end
      end
      dpr_pkg::send_align_state: begin
        if (align_s) begin
          next_q.st = dpr_pkg::ready_state;
          next_q.resuming = 1'b0;
        end else if (align_done) begin
          if (q.resuming || q.rate == GEN_MIN) begin
            next_q.st = dpr_pkg::error_state;
          end else begin
            next_q.st = dpr_pkg::reduce_speed_state;
            next_q.rate = q.rate - 2'h1;
          end
        end
      end
      dpr_pkg::ready_state: begin
        if (link_partial_req) begin
          next_q.st = dpr_pkg::partial_power_state;
        end else if (link_slumber_req) begin
          next_q.st = dpr_pkg::slumber_power_state;
        end else if (ASYNC_RECOVERY && !rx_s) begin
          next_q.st = dpr_pkg::error_state;
        end
      end
      dpr_pkg::partial_power_state: begin
        // stay while held; the wake that follows is a resume at the same rate
        if (!link_partial_req) begin
          next_q.resuming = 1'b1;
          next_q.st = wake_s ? dpr_pkg::await_wake_release_state
                             : dpr_pkg::wake_signal_state;
        end
      end
      dpr_pkg::slumber_power_state: begin
        if (!link_slumber_req) begin
          next_q.resuming = 1'b1;
          next_q.st = wake_s ? dpr_pkg::await_wake_release_state
                             : dpr_pkg::wake_signal_state;
        end
      end
      dpr_pkg::reduce_speed_state: begin
        // the switch counts only with a valid transmitter
        if (spd_s && txv_s) begin
          next_q.st = dpr_pkg::send_align_state;
        end
      end
      dpr_pkg::error_state: begin
        if (q.resuming) begin
          next_q.st = dpr_pkg::wake_signal_state;
        end else if (ASYNC_RECOVERY && recov_done) begin
          next_q.st = dpr_pkg::reset_state;
        end
        // otherwise hold
      end
    endcase
    next_q.phy_ready = (next_q.st == dpr_pkg::ready_state) && rx_s && txv_s;
    next_q.quiescent = (next_q.st == dpr_pkg::partial_power_state) ||
                       (next_q.st == dpr_pkg::slumber_power_state) ||
                       (next_q.st == dpr_pkg::reduce_speed_state) ||
                       (next_q.st == dpr_pkg::error_state);
    next_q.tx_align = (next_q.st == dpr_pkg::send_align_state);
    next_q.tx_wake = (next_q.st == dpr_pkg::wake_signal_state);
    next_q.rate_req = (next_q.st == dpr_pkg::reduce_speed_state);
  end

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      q <= '{st: dpr_pkg::reset_state, rate: `DPR_GEN_MAX, quiescent: 1'b1, default: '0};
    end else begin
      q <= next_q;
    end
  end

  assign phy_ready_ind = q.phy_ready;
  assign iface_quiescent = q.quiescent;
  assign tx_align = q.tx_align;
  assign tx_wake = q.tx_wake;
  assign rate_change_req = q.rate_req;
  assign rate_gen = q.rate;

  default clocking dpr_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_q);

  property p_ready_only;
    phy_ready_ind |-> (q.st == dpr_pkg::ready_state) && $past(rx_s) && $past(txv_s);
  endproperty
  a_ready_only: assert property (p_ready_only) else $error("phy ready outside ready");

  property p_partial_exit;
    (q.st == dpr_pkg::partial_power_state) |=>
      $past(link_partial_req) ? (q.st == dpr_pkg::partial_power_state) :
      ($past(wake_s) ? (q.st == dpr_pkg::await_wake_release_state)
                     : (q.st == dpr_pkg::wake_signal_state));
  endproperty
  a_partial_exit: assert property (p_partial_exit) else $error("bad partial exit");

  // destination checked too, so a wrong exit state cannot slip through on the flags alone
  property p_slumber_exit;
    (q.st == dpr_pkg::slumber_power_state) && !link_slumber_req |=>
      iface_quiescent == 1'b0 && q.resuming &&
      (q.st == ($past(wake_s) ? dpr_pkg::await_wake_release_state
                              : dpr_pkg::wake_signal_state));
  endproperty
  a_slumber_exit: assert property (p_slumber_exit) else $error("bad slumber exit");

  property p_reduce_done;
    (q.st == dpr_pkg::reduce_speed_state) && spd_s && txv_s |=> tx_align;
  endproperty
  a_reduce_done: assert property (p_reduce_done) else $error("reduce not left");

  property p_reduce_hold;
    (q.st == dpr_pkg::reduce_speed_state) && !spd_s |=> rate_change_req && iface_quiescent;
  endproperty
  a_reduce_hold: assert property (p_reduce_hold) else $error("reduce left early");

  property p_switch_valid;
    (q.st == dpr_pkg::reduce_speed_state) ##1 (q.st == dpr_pkg::send_align_state)
      |-> $past(txv_s, 1) && $past(spd_s, 1);
  endproperty
  a_switch_valid: assert property (p_switch_valid) else $error("switch w/o valid tx");

  property p_error_hold;
    (q.st == dpr_pkg::error_state) && !q.resuming && !recov_done |=>
      (q.st == dpr_pkg::error_state);
  endproperty
  a_error_hold: assert property (p_error_hold) else $error("error left early");

  property p_error_retry;
    (q.st == dpr_pkg::error_state) && q.resuming |=> tx_wake && q.resuming;
  endproperty
  a_error_retry: assert property (p_error_retry) else $error("no wake retry");

  property p_error_recov;
    (q.st == dpr_pkg::error_state) && !q.resuming && recov_done && ASYNC_RECOVERY |=>
      (q.st == dpr_pkg::reset_state) ##1 (rate_gen == GEN_MAX);
  endproperty
  a_error_recov: assert property (p_error_recov) else $error("no recovery reset");

  property p_resume_rate;
    q.tx_align && align_done && !align_s && q.resuming |=>
      (q.st == dpr_pkg::error_state) && $stable(rate_gen);
  endproperty
  a_resume_rate: assert property (p_resume_rate) else $error("resume changed rate");

  property p_align_fail;
    q.tx_align && align_done && !align_s && !q.resuming && (rate_gen != GEN_MIN) |=>
      rate_change_req;
  endproperty
  a_align_fail: assert property (p_align_fail) else $error("no reduce on timeout");

  property p_next_gen;
    $rose(rate_change_req) |-> rate_gen == 2'($past(rate_gen) - 2'h1);
  endproperty
  a_next_gen: assert property (p_next_gen) else $error("rate not lowered by one");

  c_ready: cover property ($rose(phy_ready_ind));
  c_reduce: cover property ($rose(rate_change_req));
  c_recover: cover property ((q.st == dpr_pkg::error_state) ##1 (q.st == dpr_pkg::reset_state));
  c_wake: cover property ((q.st == dpr_pkg::slumber_power_state) ##1 tx_wake);

endmodule // dpr_fsm
`default_nettype wire

// file: verification/dpr_host_model.sv
// host phy and analog front end model facing the device power and recovery machine
// assumes the mclk domain; the bench steers it through answer_align, wake_force, lose_lock
`timescale 1ns/1ps
`default_nettype none
module dpr_host_model (
  input wire logic mclk,
  input wire logic tx_wake,
  input wire logic tx_align,
  input wire logic rate_change_req,
  input wire logic answer_align,
  input wire logic wake_force,
  input wire logic lose_lock,
  output logic host_wake_det,
  output logic host_align_det,
  output logic rx_sync_lock,
  output logic tx_signal_valid,
  output logic speed_switch_done
);
  logic [4:0] sw_cnt;
  // quiet start so the device never sees an unknown pin; one process keeps one driver
  // host echoes wake, answers aligns only when allowed; switch timer runs while asked
  initial begin
    host_wake_det = 1'b0;
    host_align_det = 1'b0;
    rx_sync_lock = 1'b1;
    sw_cnt = 5'h00;
    forever begin
      @(posedge mclk);
      host_wake_det <= tx_wake | wake_force;
      host_align_det <= tx_align & answer_align;
      rx_sync_lock <= ~lose_lock;
      sw_cnt <= rate_change_req ? sw_cnt + {4'h0, sw_cnt != 5'h1f} : 5'h00;
    end
  end
  // switch says done well before the transmitter settles, so done alone must not count
  assign speed_switch_done = sw_cnt >= 5'h06;
  assign tx_signal_valid = ~rate_change_req | (sw_cnt >= 5'h0c);
endmodule // dpr_host_model
`default_nettype wire

// file: verification/dpr_fsm_tb.sv
// self-checking bench for the device phy power and recovery machine
// assumes dpr_fsm with shortened align and recovery counts, host model beside it
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", nm, e, a); end end
module dpr_fsm_tb;
  localparam int AL_C = 20;
  logic mclk, rst_n, link_partial_req, link_slumber_req, answer_align, wake_force, lose_lock;
  logic host_wake_det, host_align_det, rx_sync_lock, tx_signal_valid, speed_switch_done;
  logic phy_ready_ind, iface_quiescent, tx_align, tx_wake, rate_change_req;
  logic [1:0] rate_gen;
  logic [4:0] obs;
  // each row: partial, slumber, host wake, then the tx_wake expected after the drop
  logic [3:0] rows [5] = '{4'h9, 4'h5, 4'ha, 4'h6, 4'hd};
  logic p, s, w, e;
  int err_count = 0, check_count = 0, cycles = 0, n;
  assign obs = {phy_ready_ind, iface_quiescent, tx_align, tx_wake, rate_change_req};
  dpr_fsm #(.ALIGN_CYCLES(AL_C), .RECOV_CYCLES(30)) dut (.mclk(mclk), .rst_n(rst_n),
    .link_partial_req(link_partial_req), .link_slumber_req(link_slumber_req),
    .rx_sync_lock(rx_sync_lock), .tx_signal_valid(tx_signal_valid),
    .host_align_det(host_align_det), .host_wake_det(host_wake_det),
    .speed_switch_done(speed_switch_done), .phy_ready_ind(phy_ready_ind),
    .iface_quiescent(iface_quiescent), .tx_align(tx_align), .tx_wake(tx_wake),
    .rate_change_req(rate_change_req), .rate_gen(rate_gen));
  dpr_host_model host (.mclk(mclk), .tx_wake(tx_wake), .tx_align(tx_align),
    .rate_change_req(rate_change_req), .answer_align(answer_align), .wake_force(wake_force),
    .lose_lock(lose_lock), .host_wake_det(host_wake_det), .host_align_det(host_align_det),
    .rx_sync_lock(rx_sync_lock), .tx_signal_valid(tx_signal_valid),
    .speed_switch_done(speed_switch_done));
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task give_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // bounded wait on one watched output, n returns the cycles spent
  task wait_bit(input int b, input logic v);
    n = 0;
    while (obs[b] !== v && n < 400) begin
      cyc(1);
      n++;
    end
  endtask
  task wait_ready();
    wait_bit(4, 1'b1);
    `CHK("ready", 1'b1, phy_ready_ind)
  endtask
  // ready only with no other activity; hang guard sized for about 330 cycles of tests
  always @(negedge mclk) begin
    cycles++;
    if (phy_ready_ind === 1'b1) begin
      `CHK("rdy_alone", 1'b0, iface_quiescent | tx_align | tx_wake)
    end
    if (cycles == 6000) begin
      err_count++;
      give_verdict();
    end
  end
  // main sequence: power-state table first, then resume failure, speed drop, lost lock
  initial begin
    rst_n = 1'b0;
    link_partial_req = 1'b0;
    link_slumber_req = 1'b0;
    answer_align = 1'b1;
    wake_force = 1'b0;
    lose_lock = 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    wait_ready();
    foreach (rows[i]) begin
      {p, s, w, e} = rows[i];
      @(posedge mclk);
      link_partial_req <= p;
      link_slumber_req <= s;
      wake_force <= w;
      cyc(8);
      `CHK("quiet", 1'b1, iface_quiescent)
      @(posedge mclk);
      link_partial_req <= 1'b0;
      link_slumber_req <= 1'b0;
      cyc(2);
      `CHK("wake_tx", e, tx_wake)
      `CHK("active", 1'b0, iface_quiescent)
      @(posedge mclk);
      wake_force <= 1'b0;
      wait_ready();
      `CHK("resume_rate", 2'h2, rate_gen)
    end
    // failed resume: straight to error at the old rate, then wake retry
    @(posedge mclk);
    link_slumber_req <= 1'b1;
    cyc(4);
    @(posedge mclk);
    link_slumber_req <= 1'b0;
    answer_align <= 1'b0;
    wait_bit(2, 1'b1);
    wait_bit(2, 1'b0);
    `CHK("err_rate", 3'h4, {rate_gen, rate_change_req})
    `CHK("err_quiet", 1'b1, iface_quiescent)
    cyc(1);
    `CHK("retry", 1'b1, tx_wake)
    @(posedge mclk);
    answer_align <= 1'b1;
    wait_ready();
    // reset mid-run, then no host answer: speed drop and error at the floor
    @(posedge mclk);
    rst_n <= 1'b0;
    answer_align <= 1'b0;
    cyc(2);
    `CHK("rst_out", 7'h22, {obs, rate_gen})
    @(posedge mclk);
    rst_n <= 1'b1;
    wait_bit(2, 1'b1);
    wait_bit(2, 1'b0);
    `CHK("align_time", 1'b1, n >= AL_C && n <= AL_C + 2)
    `CHK("slow_rate", 2'h1, rate_gen)
    `CHK("rate_req", 2'h3, {rate_change_req, iface_quiescent})
    cyc(10);
    `CHK("hold_slow", 1'b1, rate_change_req)
    wait_bit(2, 1'b1);
    `CHK("slow_done", 1'b1, n <= 12)
    wait_bit(2, 1'b0);
    `CHK("floor_err", 3'h2, {rate_gen, rate_change_req})
    cyc(20);
    `CHK("err_hold", 2'h2, {iface_quiescent, tx_wake})
    wait_bit(1, 1'b1);
    `CHK("recov", 1'b1, n >= 8 && n <= 20)
    `CHK("recov_rate", 2'h2, rate_gen)
    // lost receiver lock in ready
    @(posedge mclk);
    answer_align <= 1'b1;
    wait_ready();
    @(posedge mclk);
    lose_lock <= 1'b1;
    wait_bit(4, 1'b0);
    `CHK("lock_loss", 1'b1, n == 5)
    @(posedge mclk);
    lose_lock <= 1'b0;
    wait_ready();
    give_verdict();
  end
endmodule // dpr_fsm_tb
`undef CHK
`default_nettype wire
